// ---- dv/shift_master_model.sv ----
`timescale 1ns/100ps
module shift_master_model (
  // pins
  output logic sck,
  output logic sdo,
  input wire logic sdi
);
  logic pol;
  initial begin
    pol = 1'b0;
    sck = 1'b0;
    sdo = 1'b0;
  end
  // moves the idle clock level; only while the device is neither sending nor receiving
  task automatic idle(input logic p);
    #7;
    pol = p;
    sck = p;
    #400;
  endtask : idle
  // device answers behind its synchroniser, so bits are read late in the phase at the idle clock level
  task automatic frame(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h000;
    #7;
    for (int i = 0; i < n; i++) begin
      sck = ~pol;
      sdo = d[i];
      #100;
      sck = pol;
      #100;
      q[i] = sdi;
    end
    sdo = ~sdo;
    #400;
  endtask : frame
endmodule : shift_master_model

// ---- dv/sync_slave_serial_port_asserts.sv ----
`timescale 1ns/100ps
module sync_slave_serial_port_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [serial_port_pkg::BUS_WIDTH-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and requests
  input wire logic shift_clock_out,
  input wire logic shift_clock_oe_n,
  input wire logic wake_request,
  input wire logic irq_request
);
  import serial_port_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  AST_READY_ZERO_WAIT:
    assert property (setup_s |=> pready) else $error("ready late");
  AST_READY_PULSE:
    assert property (access_s |=> !pready) else $error("ready held");
  AST_READY_CAUSE:
    assert property ($rose(pready) |-> $past(psel) && !$past(penable)) else $error("ready unasked");
  AST_SLVERR_QUAL:
    assert property (pslverr |-> pready) else $error("stray slverr");
  AST_RDATA_UPPER:
    assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  AST_CLK_OE_OFF:
    assert property (shift_clock_oe_n) else $error("clock pin driven");
  AST_CLK_OUT_LOW:
    assert property (!shift_clock_out) else $error("clock out active");
  AST_IRQ_NEEDS_WAKE:
    assert property (irq_request |-> wake_request) else $error("irq without wake");
endmodule : sync_slave_serial_port_asserts
bind sync_slave_serial_port sync_slave_serial_port_asserts asserts_u (.core_clk, .reset_n, .psel, .penable,
  .prdata, .pready, .pslverr, .shift_clock_out, .shift_clock_oe_n, .wake_request, .irq_request);

// ---- dv/sync_slave_serial_port_tb.sv ----
`timescale 1ns/100ps
module sync_slave_serial_port_tb;
  import serial_port_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] x; logic e;} row_type;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, r;
  logic pready, pslverr, shift_clock_out, shift_clock_oe_n, serial_data_out, serial_data_oe_n;
  logic wake_request, irq_request, shift_clock_in, sdo, err;
  logic [8:0] got;
  wire serial_data_in = serial_data_oe_n ? sdo : serial_data_out;
  int error_cnt = 0;
  int samples_checked = 0;
  row_type rows [6] = '{'{ADDR_INTERRUPT_CONTROL, 8'hC0, 8'hFF, 8'hC0, 1'b0},
    '{ADDR_PERIPHERAL_IRQ_ENABLE_ONE, 8'h30, 8'hFF, 8'h30, 1'b0},
    '{ADDR_TRANSMIT_STATUS_CONTROL, 8'h61, 8'hF1, 8'h61, 1'b0},
    '{ADDR_BAUD_CONTROL, 8'h10, 8'h10, 8'h10, 1'b0}, '{ADDR_BAUD_CONTROL, 8'h00, 8'h10, 8'h00, 1'b0},
    '{8'h20, 8'hFF, 8'hFF, 8'h00, 1'b1}};
  always #12.5 core_clk = ~core_clk;
  sync_slave_serial_port dut_u (.core_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .shift_clock_in, .shift_clock_out, .shift_clock_oe_n, .serial_data_in,
    .serial_data_out, .serial_data_oe_n, .wake_request, .irq_request);
  shift_master_model master_u (.sck(shift_clock_in), .sdo(sdo), .sdi(serial_data_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && k++ < 20);
    if (k > 20) begin
      error_cnt++;
      end_of_test();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 8'h00);
      chk("reg", {24'h000000, rows[i].x}, r & {24'hFFFFFF, rows[i].m});
      chk("slverr", {31'h0, rows[i].e}, {31'h0, err});
    end
    apb(ADDR_INTERRUPT_CONTROL, 1'b1, 8'h40);
    apb(ADDR_PERIPHERAL_IRQ_ENABLE_ONE, 1'b1, 8'h10);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 8'h80);
    apb(ADDR_TRANSMIT_STATUS_CONTROL, 1'b1, 8'h71);
    apb(ADDR_TRANSMIT_HOLDING, 1'b1, 8'hA5);
    apb(ADDR_TRANSMIT_HOLDING, 1'b1, 8'h3C);
    apb(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 1'b0, 8'h00);
    chk("tx_flag", 32'h0, r & 32'h10);
    chk("wake", 32'h0, {31'h0, wake_request});
    chk("data_oe_n", 32'h0, {31'h0, serial_data_oe_n});
    master_u.frame(9'h000, 9, got);
    chk("tx_first", 32'h1A5, {23'h0, got});
    apb(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 1'b0, 8'h00);
    chk("tx_flag", 32'h10, r & 32'h10);
    chk("wake", 32'h1, {31'h0, wake_request});
    chk("irq", 32'h0, {31'h0, irq_request});
    apb(ADDR_INTERRUPT_CONTROL, 1'b1, 8'hC0);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h1, {31'h0, irq_request});
    master_u.frame(9'h000, 9, got);
    chk("tx_second", 32'h13C, {23'h0, got});
    apb(ADDR_TRANSMIT_STATUS_CONTROL, 1'b1, 8'h10);
    apb(ADDR_PERIPHERAL_IRQ_ENABLE_ONE, 1'b1, 8'h20);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 8'hE0);
    master_u.frame(9'h15A, 9, got);
    apb(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 1'b0, 8'h00);
    chk("rx_flag", 32'h0, r & 32'h20);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 8'hD0);
    master_u.frame(9'h15A, 9, got);
    apb(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 1'b0, 8'h00);
    chk("rx_flag", 32'h20, r & 32'h20);
    chk("wake", 32'h1, {31'h0, wake_request});
    master_u.frame(9'h0C3, 9, got);
    master_u.frame(9'h1FF, 9, got);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 8'h00);
    chk("rx_status", 32'hD3, r);
    apb(ADDR_RECEIVE_DATA, 1'b0, 8'h00);
    chk("rx_data", 32'h5A, r);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 8'h00);
    chk("rx_status", 32'hD2, r);
    apb(ADDR_RECEIVE_DATA, 1'b0, 8'h00);
    chk("rx_data", 32'hC3, r);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 8'hC0);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 8'h00);
    chk("rx_status", 32'hC0, r);
    apb(ADDR_BAUD_CONTROL, 1'b1, 8'h10);
    master_u.idle(1'b1);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 8'h90);
    master_u.frame(9'h0C6, 8, got);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 8'h00);
    chk("rx_status", 32'h90, r);
    apb(ADDR_RECEIVE_DATA, 1'b0, 8'h00);
    chk("rx_data", 32'hC6, r);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("data_oe_n", 32'h1, {31'h0, serial_data_oe_n});
    chk("clk_oe_n", 32'h1, {31'h0, shift_clock_oe_n});
    chk("clk_out", 32'h0, {31'h0, shift_clock_out});
    chk("wake", 32'h0, {31'h0, wake_request});
    reset_n <= 1'b1;
    apb(ADDR_TRANSMIT_STATUS_CONTROL, 1'b0, 8'h00);
    chk("tx_status", 32'h02, r);
    end_of_test();
  end
endmodule : sync_slave_serial_port_tb

// ---- pkg/rx_fifo_if.sv ----
`timescale 1ns/100ps
interface rx_fifo_if #(parameter int WIDTH = 9);
  logic push;
  logic [WIDTH-1:0] push_data;
  logic pop;
  logic flush;
  logic [WIDTH-1:0] head;
  logic full;
  logic empty;
  modport producer (output push, push_data, pop, flush, input head, full, empty);
  modport storage (input push, push_data, pop, flush, output head, full, empty);
endinterface : rx_fifo_if

// ---- pkg/serial_port_pkg.sv ----
package serial_port_pkg;
  // bus geometry
  localparam int ADDR_WIDTH = 8;
  localparam int BUS_WIDTH = 32;
  // register byte addresses
  localparam logic [ADDR_WIDTH-1:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RECEIVE_STATUS_CONTROL = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] ADDR_TRANSMIT_HOLDING = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RECEIVE_DATA = 8'h0C;
  localparam logic [ADDR_WIDTH-1:0] ADDR_BAUD_CONTROL = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] ADDR_INTERRUPT_CONTROL = 8'h14;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PERIPHERAL_IRQ_ENABLE_ONE = 8'h18;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PERIPHERAL_IRQ_FLAGS_ONE = 8'h1C;
  // transmit_status_control fields
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int TRANSMIT_NINE_BIT_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT = 5;
  localparam int SYNC_SELECT_BIT = 4;
  localparam int TRANSMIT_SHIFT_EMPTY_BIT = 1;
  localparam int TRANSMIT_NINTH_DATA_BIT = 0;
  // receive_status_control fields
  localparam int PORT_ENABLE_BIT = 7;
  localparam int RECEIVE_NINE_BIT_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int OVERRUN_FLAG_BIT = 1;
  localparam int RECEIVE_NINTH_DATA_BIT = 0;
  // baud_control fields
  localparam int RECEIVE_IDLE_BIT = 6;
  localparam int CLOCK_POLARITY_SELECT_BIT = 4;
  // interrupt_control fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  // peripheral enable and flag fields
  localparam int RECEIVE_IRQ_BIT = 5;
  localparam int TRANSMIT_IRQ_BIT = 4;
  // character geometry
  localparam int CHAR_WIDTH = 9;
  localparam int FIFO_DEPTH = 2;
  localparam int NINTH_INDEX = 8;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [BUS_WIDTH-1:0] WORD_ZERO = 32'h00000000;
  // transmit sequencer
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_type;
endpackage : serial_port_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  wire [WIDTH-1:0] agree = ~(stage2_reg ^ stage3_reg);
  wire [WIDTH-1:0] level_next = (stage2_reg & agree) | (level_reg & ~agree);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : pin_sync

// ---- src/rx_fifo.sv ----
`timescale 1ns/100ps
module rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // storage side
  rx_fifo_if.storage fifo
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] wr_ptr_reg;
  logic [PW:0] count_reg;
  wire do_push = fifo.push & ~fifo.full;
  wire do_pop = fifo.pop & ~fifo.empty;
  wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
  wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= fifo.push_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else if (fifo.flush) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign fifo.head = mem[rd_ptr_reg];
  assign fifo.full = (count_reg == (PW + 1)'(DEPTH));
  assign fifo.empty = (count_reg == '0);
endmodule : rx_fifo

// ---- src/sync_slave_serial_port.sv ----
`timescale 1ns/100ps
module sync_slave_serial_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic [serial_port_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::BUS_WIDTH-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [serial_port_pkg::BUS_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // shift clock pin
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe_n,
  // serial data pin
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  // wake and interrupt requests
  output logic wake_request,
  output logic irq_request
);
  import serial_port_pkg::*;

  // software controls
  logic clock_source_select_reg;
  logic transmit_nine_bit_reg;
  logic transmit_enable_reg;
  logic sync_select_reg;
  logic transmit_ninth_data_reg;
  logic port_enable_reg;
  logic receive_nine_bit_reg;
  logic single_receive_enable_reg;
  logic continuous_receive_enable_reg;
  logic clock_polarity_select_reg;
  logic global_irq_enable_reg;
  logic peripheral_irq_enable_reg;
  logic receive_irq_enable_reg;
  logic transmit_irq_enable_reg;

  // serial state
  tx_state_type tx_state_reg;
  logic [7:0] transmit_holding_reg;
  logic holding_full_reg;
  logic [CHAR_WIDTH-1:0] transmit_shift_register_reg;
  logic [3:0] tx_count_reg;
  logic [3:0] tx_total_reg;
  logic [CHAR_WIDTH-1:0] receive_shift_register_reg;
  logic [3:0] rx_count_reg;
  logic overrun_flag_reg;
  logic clock_prev_reg;

  // output flops
  logic [BUS_WIDTH-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic serial_data_out_reg;
  logic serial_data_oe_n_reg;
  logic shift_clock_oe_n_reg;
  logic wake_request_reg;
  logic irq_request_reg;

  // pin synchronisers and receive fifo
  logic [1:0] pin_level;
  rx_fifo_if #(.WIDTH(CHAR_WIDTH)) fifo_bus ();

  pin_sync #(.WIDTH(2)) pin_sync_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin_in({serial_data_in, shift_clock_in}),
    .level(pin_level)
  );

  rx_fifo #(.WIDTH(CHAR_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fifo(fifo_bus)
  );

  wire clock_level = pin_level[0];
  wire data_level = pin_level[1];

  // bus decode
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready_reg;
  wire wr_access = access_done & pwrite & pstrb[0];
  wire rd_access = access_done & ~pwrite;
  wire hit_txsc = (paddr == ADDR_TRANSMIT_STATUS_CONTROL);
  wire hit_rxsc = (paddr == ADDR_RECEIVE_STATUS_CONTROL);
  wire hit_hold = (paddr == ADDR_TRANSMIT_HOLDING);
  wire hit_rdat = (paddr == ADDR_RECEIVE_DATA);
  wire hit_baud = (paddr == ADDR_BAUD_CONTROL);
  wire hit_intc = (paddr == ADDR_INTERRUPT_CONTROL);
  wire hit_pie = (paddr == ADDR_PERIPHERAL_IRQ_ENABLE_ONE);
  wire hit_pir = (paddr == ADDR_PERIPHERAL_IRQ_FLAGS_ONE);
  wire hit_any = hit_txsc | hit_rxsc | hit_hold | hit_rdat | hit_baud | hit_intc | hit_pie | hit_pir;

  // mode selection
  wire slave_active = port_enable_reg & sync_select_reg & ~clock_source_select_reg;
  wire port_clear = ~port_enable_reg;
  wire receive_mode = single_receive_enable_reg | continuous_receive_enable_reg;
  wire tx_active = slave_active & ~receive_mode & transmit_enable_reg;
  wire rx_active = slave_active & continuous_receive_enable_reg;

  // shift clock edges
  wire clock_rise = clock_level & ~clock_prev_reg;
  wire clock_fall = ~clock_level & clock_prev_reg;
  wire leading_edge = clock_polarity_select_reg ? clock_fall : clock_rise;
  wire trailing_edge = clock_polarity_select_reg ? clock_rise : clock_fall;

  // transmit path
  wire hold_write = wr_access & hit_hold;
  wire tx_idle = (tx_state_reg == TX_IDLE);
  wire load_shift = tx_idle & holding_full_reg & tx_active;
  wire [3:0] tx_count_inc = tx_count_reg + 1'b1;
  wire tx_last = trailing_edge & (tx_count_inc == tx_total_reg);
  wire [3:0] char_total_tx = transmit_nine_bit_reg ? BITS_LONG : BITS_SHORT;
  wire holding_full_next = hold_write | (holding_full_reg & ~load_shift);
  wire transmit_buffer_empty_flag = ~holding_full_reg;

  // receive path
  wire [3:0] char_total_rx = receive_nine_bit_reg ? BITS_LONG : BITS_SHORT;
  wire rx_sample = trailing_edge & rx_active & ~overrun_flag_reg;
  wire [CHAR_WIDTH-1:0] rx_shifted = {data_level, receive_shift_register_reg[CHAR_WIDTH-1:1]};
  wire [3:0] rx_count_inc = rx_count_reg + 1'b1;
  wire rx_complete = rx_sample & (rx_count_inc == char_total_rx);
  wire [CHAR_WIDTH-1:0] rx_char = receive_nine_bit_reg ? rx_shifted : {1'b0, rx_shifted[CHAR_WIDTH-1:1]};
  wire overrun_set = rx_complete & fifo_bus.full;
  wire overrun_next = overrun_set | (overrun_flag_reg & continuous_receive_enable_reg & port_enable_reg);
  wire receive_complete_flag = ~fifo_bus.empty;
  wire receive_ninth_data = fifo_bus.head[NINTH_INDEX] & ~fifo_bus.empty;
  wire receive_idle = (rx_count_reg == '0);

  assign fifo_bus.push = rx_complete & ~fifo_bus.full;
  assign fifo_bus.push_data = rx_char;
  assign fifo_bus.pop = rd_access & hit_rdat;
  assign fifo_bus.flush = port_clear;

  // events toward the core
  wire tx_event = transmit_buffer_empty_flag & transmit_irq_enable_reg;
  wire rx_event = receive_complete_flag & receive_irq_enable_reg;
  wire wake_next = peripheral_irq_enable_reg & (tx_event | rx_event);
  wire irq_next = wake_next & global_irq_enable_reg;

  // register images
  logic [7:0] txsc_byte;
  logic [7:0] rxsc_byte;
  logic [7:0] baud_byte;
  logic [7:0] intc_byte;
  logic [7:0] pie_byte;
  logic [7:0] pir_byte;

  always_comb begin
    txsc_byte = BYTE_ZERO;
    txsc_byte[CLOCK_SOURCE_SELECT_BIT] = clock_source_select_reg;
    txsc_byte[TRANSMIT_NINE_BIT_BIT] = transmit_nine_bit_reg;
    txsc_byte[TRANSMIT_ENABLE_BIT] = transmit_enable_reg;
    txsc_byte[SYNC_SELECT_BIT] = sync_select_reg;
    txsc_byte[TRANSMIT_SHIFT_EMPTY_BIT] = tx_idle;
    txsc_byte[TRANSMIT_NINTH_DATA_BIT] = transmit_ninth_data_reg;
    rxsc_byte = BYTE_ZERO;
    rxsc_byte[PORT_ENABLE_BIT] = port_enable_reg;
    rxsc_byte[RECEIVE_NINE_BIT_BIT] = receive_nine_bit_reg;
    rxsc_byte[SINGLE_RECEIVE_ENABLE_BIT] = single_receive_enable_reg;
    rxsc_byte[CONTINUOUS_RECEIVE_ENABLE_BIT] = continuous_receive_enable_reg;
    rxsc_byte[OVERRUN_FLAG_BIT] = overrun_flag_reg;
    rxsc_byte[RECEIVE_NINTH_DATA_BIT] = receive_ninth_data;
    baud_byte = BYTE_ZERO;
    baud_byte[RECEIVE_IDLE_BIT] = receive_idle;
    baud_byte[CLOCK_POLARITY_SELECT_BIT] = clock_polarity_select_reg;
    intc_byte = BYTE_ZERO;
    intc_byte[GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_reg;
    intc_byte[PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_reg;
    pie_byte = BYTE_ZERO;
    pie_byte[RECEIVE_IRQ_BIT] = receive_irq_enable_reg;
    pie_byte[TRANSMIT_IRQ_BIT] = transmit_irq_enable_reg;
    pir_byte = BYTE_ZERO;
    pir_byte[RECEIVE_IRQ_BIT] = receive_complete_flag;
    pir_byte[TRANSMIT_IRQ_BIT] = transmit_buffer_empty_flag;
  end

  wire [7:0] read_byte = hit_txsc ? txsc_byte :
                         hit_rxsc ? rxsc_byte :
                         hit_rdat ? fifo_bus.head[7:0] :
                         hit_baud ? baud_byte :
                         hit_intc ? intc_byte :
                         hit_pie ? pie_byte :
                         hit_pir ? pir_byte : BYTE_ZERO;

  // apb answer, captured in the setup cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= WORD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~hit_any;
      if (setup_phase) begin
        prdata_reg <= {24'h000000, read_byte};
      end
    end
  end

  // control register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_source_select_reg <= 1'b0;
      transmit_nine_bit_reg <= 1'b0;
      transmit_enable_reg <= 1'b0;
      sync_select_reg <= 1'b0;
      transmit_ninth_data_reg <= 1'b0;
    end else if (wr_access && hit_txsc) begin
      clock_source_select_reg <= pwdata[CLOCK_SOURCE_SELECT_BIT];
      transmit_nine_bit_reg <= pwdata[TRANSMIT_NINE_BIT_BIT];
      transmit_enable_reg <= pwdata[TRANSMIT_ENABLE_BIT];
      sync_select_reg <= pwdata[SYNC_SELECT_BIT];
      transmit_ninth_data_reg <= pwdata[TRANSMIT_NINTH_DATA_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_enable_reg <= 1'b0;
      receive_nine_bit_reg <= 1'b0;
      single_receive_enable_reg <= 1'b0;
      continuous_receive_enable_reg <= 1'b0;
    end else if (wr_access && hit_rxsc) begin
      port_enable_reg <= pwdata[PORT_ENABLE_BIT];
      receive_nine_bit_reg <= pwdata[RECEIVE_NINE_BIT_BIT];
      single_receive_enable_reg <= pwdata[SINGLE_RECEIVE_ENABLE_BIT];
      continuous_receive_enable_reg <= pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_polarity_select_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
      peripheral_irq_enable_reg <= 1'b0;
      receive_irq_enable_reg <= 1'b0;
      transmit_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_access && hit_baud) begin
        clock_polarity_select_reg <= pwdata[CLOCK_POLARITY_SELECT_BIT];
      end
      if (wr_access && hit_intc) begin
        global_irq_enable_reg <= pwdata[GLOBAL_IRQ_ENABLE_BIT];
        peripheral_irq_enable_reg <= pwdata[PERIPHERAL_IRQ_ENABLE_BIT];
      end
      if (wr_access && hit_pie) begin
        receive_irq_enable_reg <= pwdata[RECEIVE_IRQ_BIT];
        transmit_irq_enable_reg <= pwdata[TRANSMIT_IRQ_BIT];
      end
    end
  end

  // transmit holding register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_holding_reg <= BYTE_ZERO;
      holding_full_reg <= 1'b0;
    end else if (port_clear) begin
      holding_full_reg <= 1'b0;
    end else begin
      holding_full_reg <= holding_full_next;
      if (hold_write) begin
        transmit_holding_reg <= pwdata[7:0];
      end
    end
  end

  // transmit sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= TX_IDLE;
      transmit_shift_register_reg <= '0;
      tx_count_reg <= '0;
      tx_total_reg <= BITS_SHORT;
      serial_data_out_reg <= 1'b0;
    end else if (port_clear) begin
      tx_state_reg <= TX_IDLE;
      tx_count_reg <= '0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (load_shift) begin
            transmit_shift_register_reg <= {transmit_ninth_data_reg, transmit_holding_reg};
            tx_total_reg <= char_total_tx;
            tx_count_reg <= '0;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (!tx_active) begin
            tx_state_reg <= TX_IDLE;
          end else begin
            if (leading_edge) begin
              serial_data_out_reg <= transmit_shift_register_reg[0];
              transmit_shift_register_reg <= transmit_shift_register_reg >> 1;
            end
            if (trailing_edge) begin
              tx_count_reg <= tx_count_inc;
            end
            if (tx_last) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // receive shifter and overrun
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_shift_register_reg <= '0;
      rx_count_reg <= '0;
      overrun_flag_reg <= 1'b0;
    end else if (!rx_active) begin
      rx_count_reg <= '0;
      overrun_flag_reg <= overrun_next;
    end else begin
      overrun_flag_reg <= overrun_next;
      if (rx_complete) begin
        rx_count_reg <= '0;
        receive_shift_register_reg <= rx_shifted;
      end else if (rx_sample) begin
        rx_count_reg <= rx_count_inc;
        receive_shift_register_reg <= rx_shifted;
      end
    end
  end

  // pins and event outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_prev_reg <= 1'b0;
      serial_data_oe_n_reg <= 1'b1;
      shift_clock_oe_n_reg <= 1'b1;
      wake_request_reg <= 1'b0;
      irq_request_reg <= 1'b0;
    end else begin
      clock_prev_reg <= clock_level;
      serial_data_oe_n_reg <= ~tx_active;
      shift_clock_oe_n_reg <= 1'b1;
      wake_request_reg <= wake_next;
      irq_request_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign shift_clock_out = 1'b0 & shift_clock_oe_n_reg;
  assign shift_clock_oe_n = shift_clock_oe_n_reg;
  assign serial_data_out = serial_data_out_reg;
  assign serial_data_oe_n = serial_data_oe_n_reg;
  assign wake_request = wake_request_reg;
  assign irq_request = irq_request_reg;
endmodule : sync_slave_serial_port
